/* design/fam_host.sv */
// Purpose: Host controller issuing auxiliary-mode command sequences to a flash
// Assumes: Device already placed in a mode by other logic (op_assume_mode)
// Notes:   Keeps a mirror of the device command state, updated per bus cycle
`timescale 1ns/10ps
`default_nettype none
`include "fam_params.svh"

// Contract
// - Lock mode: F0 exits, 70 status, 71 stays
// - Lock mode: 90 then 00/03 exits; A0 programs
// - Secure mode: AA@555 unlocks, F0 exits, 70 status
// - Unlock two: A0, 25@sector, 90, F0 branches
module fam_host #(
  parameter int ADDR_W = 26,
  parameter int DATA_W = 16
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic              i_cmd_valid,
  input  wire logic [3:0]        i_cmd_op,
  input  wire logic [ADDR_W-1:0] i_cmd_addr,
  input  wire logic [DATA_W-1:0] i_cmd_data,
  input  wire logic              i_abort_cond,
  input  wire logic [DATA_W-1:0] i_dq,
  output logic                   o_cmd_ready,
  output logic                   o_done,
  output logic [DATA_W-1:0]      o_rd_data,
  output logic [3:0]             o_mode,
  output logic                   o_ce_n,
  output logic                   o_we_n,
  output logic                   o_oe_n,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [DATA_W-1:0]      o_dq,
  output logic                   o_dq_oe
);

  typedef enum logic [1:0] {
    fam_h_idle  = 2'h0,
    fam_h_start = 2'h1,
    fam_h_wait  = 2'h2
  } fam_host_state_t;

  localparam logic [`FAM_CMD_ADDR_BITS-1:0] A555 = `FAM_ADDR_UNLOCK1;
  localparam logic [`FAM_CMD_ADDR_BITS-1:0] A2AA = `FAM_ADDR_UNLOCK2;
  localparam logic [`FAM_CMD_ADDR_BITS-1:0] AANY = `FAM_ADDR_ANY;

  fam_host_state_t   state, next_state;
  fam_pkg::fam_op_t  op, next_op;
  fam_pkg::fam_mode_t mode, next_mode, ret_mode, next_ret_mode;
  logic [ADDR_W-1:0] uaddr, next_uaddr;
  logic [DATA_W-1:0] udata, next_udata;
  logic              step, next_step;
  logic              bus_start, next_bus_start;
  logic              next_ready, next_done;
  logic              bus_done;
  logic [DATA_W-1:0] bus_rd_data;
  logic [DATA_W-1:0] next_rd_data;
  // Current step of the sequence
  logic              s_read, s_last;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_data;
  logic [`FAM_CMD_ADDR_BITS-1:0] ca;
  logic [`FAM_CMD_BITS-1:0]      cd;

  function automatic logic [ADDR_W-1:0] cmd_addr(input logic [`FAM_CMD_ADDR_BITS-1:0] a);
    cmd_addr = {{(ADDR_W-`FAM_CMD_ADDR_BITS){1'b0}}, a};
  endfunction

  function automatic logic [DATA_W-1:0] cmd_data(input logic [`FAM_CMD_BITS-1:0] d);
    cmd_data = {{(DATA_W-`FAM_CMD_BITS){1'b0}}, d};
  endfunction

  // Bus cycle for each op and step
  always_comb begin
    s_read = 1'b0;
    s_last = 1'b1;
    s_addr = cmd_addr(AANY);
    s_data = cmd_data(`FAM_CMD_RESET);
    unique case (op)
      fam_pkg::op_read: begin
        s_read = 1'b1;
        s_addr = uaddr;
      end
      fam_pkg::op_reset: begin
        s_data = cmd_data(`FAM_CMD_RESET);
      end
      fam_pkg::op_status: begin
        s_last = step;
        s_read = step;
        s_addr = step ? uaddr : cmd_addr(A555);
        s_data = cmd_data(`FAM_CMD_SR_READ);
      end
      fam_pkg::op_clear: begin
        s_addr = cmd_addr(A555);
        s_data = cmd_data(`FAM_CMD_SR_CLEAR);
      end
      fam_pkg::op_lr_exit: begin
        s_last = step;
        s_data = step ? cmd_data(`FAM_CMD_EXIT) : cmd_data(`FAM_CMD_EXIT_ENTRY);
      end
      fam_pkg::op_lr_prog: begin
        s_last = step;
        s_addr = step ? uaddr : cmd_addr(AANY);
        s_data = step ? udata : cmd_data(`FAM_CMD_PROG_ENTRY);
      end
      fam_pkg::op_sec_unlock: begin
        s_last = step;
        s_addr = step ? cmd_addr(A2AA) : cmd_addr(A555);
        s_data = step ? cmd_data(`FAM_CMD_UNLOCK2) : cmd_data(`FAM_CMD_UNLOCK1);
      end
      fam_pkg::op_sec_prog: begin
        s_last = step;
        s_addr = step ? uaddr : cmd_addr(A555);
        s_data = step ? udata : cmd_data(`FAM_CMD_PROG_ENTRY);
      end
      fam_pkg::op_sec_buf: begin
        s_addr = uaddr;
        s_data = cmd_data(`FAM_CMD_BUF_ENTER);
      end
      fam_pkg::op_sec_exit: begin
        s_last = step;
        s_addr = step ? cmd_addr(AANY) : cmd_addr(A555);
        s_data = step ? cmd_data(`FAM_CMD_EXIT) : cmd_data(`FAM_CMD_EXIT_ENTRY);
      end
      fam_pkg::op_raw_write: begin
        s_addr = uaddr;
        s_data = udata;
      end
      default: begin
        s_last = 1'b1;
      end
    endcase
  end

  // Mirror of the device state after the current bus cycle
  always_comb begin
    ca            = s_addr[`FAM_CMD_ADDR_BITS-1:0];
    cd            = s_data[`FAM_CMD_BITS-1:0];
    next_mode     = mode;
    next_ret_mode = ret_mode;
    if (s_read) begin
      if (mode == fam_pkg::lockreg_status_read || mode == fam_pkg::query_status_read ||
          mode == fam_pkg::secure_status_read) begin
        next_mode = ret_mode;
      end
    end else begin
      unique case (mode)
        fam_pkg::lockreg_mode: begin
          if (cd == `FAM_CMD_RESET) next_mode = fam_pkg::read_array;
          else if (cd == `FAM_CMD_SR_READ && ca == A555) begin
            next_mode     = fam_pkg::lockreg_status_read;
            next_ret_mode = fam_pkg::lockreg_mode;
          end
          else if (cd == `FAM_CMD_EXIT_ENTRY) next_mode = fam_pkg::lockreg_exit_pending;
          else if (cd == `FAM_CMD_PROG_ENTRY) next_mode = fam_pkg::lockreg_prog_wait;
        end
        fam_pkg::lockreg_prog_wait: next_mode = fam_pkg::lockreg_programming;
        fam_pkg::lockreg_programming: begin
          if (cd == `FAM_CMD_SR_READ && ca == A555) begin
            next_mode     = fam_pkg::lockreg_status_read;
            next_ret_mode = fam_pkg::lockreg_programming;
          end
        end
        fam_pkg::lockreg_exit_pending: begin
          if (cd == `FAM_CMD_EXIT || cd == `FAM_CMD_WORD_COUNT) next_mode = fam_pkg::read_array;
        end
        fam_pkg::query_mode: begin
          if (cd == `FAM_CMD_RESET) next_mode = fam_pkg::read_array;
          else if (cd == `FAM_CMD_SR_READ && ca == A555) begin
            next_mode     = fam_pkg::query_status_read;
            next_ret_mode = fam_pkg::query_mode;
          end
        end
        fam_pkg::secure_sector_mode, fam_pkg::secure_programming: begin
          if (cd == `FAM_CMD_RESET) next_mode = fam_pkg::read_array;
          else if (cd == `FAM_CMD_SR_READ && ca == A555) begin
            next_mode     = fam_pkg::secure_status_read;
            next_ret_mode = mode;
          end
          else if (cd == `FAM_CMD_SR_CLEAR && ca == A555) next_mode = fam_pkg::secure_sector_mode;
          else if (cd == `FAM_CMD_UNLOCK1 && ca == A555) next_mode = fam_pkg::secure_unlock_first;
        end
        fam_pkg::secure_unlock_first: begin
          if (cd == `FAM_CMD_UNLOCK2 && ca == A2AA) next_mode = fam_pkg::secure_unlock_second;
          else if (cd == `FAM_CMD_RESET) next_mode = fam_pkg::read_array;
          else if (cd == `FAM_CMD_SR_READ && ca == A555) begin
            next_mode     = fam_pkg::secure_status_read;
            next_ret_mode = fam_pkg::secure_sector_mode;
          end
          else if (i_abort_cond) next_mode = fam_pkg::secure_programming;
        end
        fam_pkg::secure_unlock_second: begin
          if (cd == `FAM_CMD_RESET) next_mode = fam_pkg::secure_sector_mode;
          else if (cd == `FAM_CMD_BUF_ENTER) next_mode = fam_pkg::secure_buffer_write;
          else if (cd == `FAM_CMD_PROG_ENTRY && ca == A555) next_mode = fam_pkg::secure_word_prog_wait;
          else if (cd == `FAM_CMD_EXIT_ENTRY && ca == A555) next_mode = fam_pkg::secure_exit_pending;
          else if (i_abort_cond) next_mode = fam_pkg::secure_programming;
        end
        fam_pkg::secure_word_prog_wait: next_mode = fam_pkg::secure_programming;
        fam_pkg::secure_exit_pending: begin
          if (cd == `FAM_CMD_EXIT) next_mode = fam_pkg::read_array;
        end
        default: next_mode = mode;
      endcase
    end
  end

  // Sequencer
  always_comb begin
    next_state     = state;
    next_op        = op;
    next_uaddr     = uaddr;
    next_udata     = udata;
    next_step      = step;
    next_bus_start = 1'b0;
    next_ready     = 1'b0;
    next_done      = 1'b0;
    next_rd_data   = o_rd_data;
    unique case (state)
      fam_h_idle: begin
        next_ready = 1'b1;
        if (i_cmd_valid) begin
          next_ready = 1'b0;
          next_op    = fam_pkg::fam_op_t'(i_cmd_op);
          next_uaddr = i_cmd_addr;
          next_udata = i_cmd_data;
          next_step  = 1'b0;
          if (i_cmd_op == fam_pkg::op_assume_mode) begin
            next_done  = 1'b1;
            next_ready = 1'b1;
          end else begin
            next_state = fam_h_start;
          end
        end
      end
      fam_h_start: begin
        next_bus_start = 1'b1;
        next_state     = fam_h_wait;
      end
      fam_h_wait: begin
        if (bus_done) begin
          if (s_read) next_rd_data = bus_rd_data;
          if (s_last) begin
            next_state = fam_h_idle;
            next_done  = 1'b1;
            next_ready = 1'b1;
          end else begin
            next_step  = 1'b1;
            next_state = fam_h_start;
          end
        end
      end
      default: next_state = fam_h_idle;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state       <= fam_h_idle;
      op          <= fam_pkg::op_read;
      mode        <= fam_pkg::read_array;
      ret_mode    <= fam_pkg::read_array;
      uaddr       <= '0;
      udata       <= '0;
      step        <= 1'b0;
      bus_start   <= 1'b0;
      o_cmd_ready <= 1'b0;
      o_done      <= 1'b0;
      o_rd_data   <= '0;
      o_mode      <= 4'h0;
    end else begin
      state       <= next_state;
      op          <= next_op;
      uaddr       <= next_uaddr;
      udata       <= next_udata;
      step        <= next_step;
      bus_start   <= next_bus_start;
      o_cmd_ready <= next_ready;
      o_done      <= next_done;
      o_rd_data   <= next_rd_data;
      if (state == fam_h_idle && i_cmd_valid && i_cmd_op == fam_pkg::op_assume_mode) begin
        mode   <= fam_pkg::fam_mode_t'(i_cmd_data[3:0]);
        o_mode <= i_cmd_data[3:0];
      end else if (state == fam_h_wait && bus_done) begin
        mode     <= next_mode;
        ret_mode <= next_ret_mode;
        o_mode   <= next_mode;
      end
    end
  end

  fam_bus_cycle #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_bus (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_start   (bus_start),
    .i_is_read (s_read),
    .i_addr    (s_addr),
    .i_data    (s_data),
    .i_dq      (i_dq),
    .o_done    (bus_done),
    .o_rd_data (bus_rd_data),
    .o_ce_n    (o_ce_n),
    .o_we_n    (o_we_n),
    .o_oe_n    (o_oe_n),
    .o_addr    (o_addr),
    .o_dq      (o_dq),
    .o_dq_oe   (o_dq_oe)
  );

endmodule

`default_nettype wire

/* design/fam_params.svh */
// Purpose: Named constants for the auxiliary-mode flash command host
// Assumes: Word-addressed parallel flash, commands in the low data byte
// Notes:   Times in ns; cycle counts are derived in the modules
`ifndef FAM_PARAMS_SVH
`define FAM_PARAMS_SVH

`define FAM_CLK_MHZ        10
`define FAM_CMD_ADDR_BITS  12
`define FAM_ADDR_UNLOCK1   12'h555
`define FAM_ADDR_UNLOCK2   12'h2aa
`define FAM_ADDR_ANY       12'h000
`define FAM_CMD_BITS       8
`define FAM_CMD_RESET      8'hf0
`define FAM_CMD_SR_READ    8'h70
`define FAM_CMD_SR_CLEAR   8'h71
`define FAM_CMD_EXIT_ENTRY 8'h90
`define FAM_CMD_EXIT       8'h00
`define FAM_CMD_WORD_COUNT 8'h03
`define FAM_CMD_PROG_ENTRY 8'ha0
`define FAM_CMD_UNLOCK1    8'haa
`define FAM_CMD_UNLOCK2    8'h55
`define FAM_CMD_BUF_ENTER  8'h25
`define FAM_T_SETUP_NS     0
`define FAM_T_WE_PULSE_NS  35
`define FAM_T_HOLD_NS      0
`define FAM_T_READ_NS      110

`endif

/* design/fam_pkg.sv */
// Purpose: Types for the auxiliary-mode flash command host
// Assumes: fam_params.svh supplies the numbers
// Notes:   Mode codes mirror the device's command state
package fam_pkg;

  typedef enum logic [3:0] {
    op_read        = 4'h0,
    op_reset       = 4'h1,
    op_status      = 4'h2,
    op_clear       = 4'h3,
    op_lr_exit     = 4'h4,
    op_lr_prog     = 4'h5,
    op_sec_unlock  = 4'h6,
    op_sec_prog    = 4'h7,
    op_sec_buf     = 4'h8,
    op_sec_exit    = 4'h9,
    op_raw_write   = 4'ha,
    op_assume_mode = 4'hb
  } fam_op_t;

  typedef enum logic [3:0] {
    read_array            = 4'h0,
    lockreg_mode          = 4'h1,
    lockreg_prog_wait     = 4'h2,
    lockreg_programming   = 4'h3,
    lockreg_status_read   = 4'h4,
    lockreg_exit_pending  = 4'h5,
    query_mode            = 4'h6,
    query_status_read     = 4'h7,
    secure_sector_mode    = 4'h8,
    secure_status_read    = 4'h9,
    secure_unlock_first   = 4'ha,
    secure_unlock_second  = 4'hb,
    secure_word_prog_wait = 4'hc,
    secure_programming    = 4'hd,
    secure_buffer_write   = 4'he,
    secure_exit_pending   = 4'hf
  } fam_mode_t;

endpackage

/* design/fam_bus_cycle.sv */
// Purpose: One asynchronous flash bus cycle, write or read, on the pins
// Assumes: Single 10 MHz clock; device pins are active low strobes
// Notes:   Data bus driven only during write cycles
`timescale 1ns/10ps
`default_nettype none
`include "fam_params.svh"

module fam_bus_cycle #(
  parameter int ADDR_W = 26,
  parameter int DATA_W = 16
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic              i_start,
  input  wire logic              i_is_read,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic [DATA_W-1:0] i_dq,
  output logic                   o_done,
  output logic [DATA_W-1:0]      o_rd_data,
  output logic                   o_ce_n,
  output logic                   o_we_n,
  output logic                   o_oe_n,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [DATA_W-1:0]      o_dq,
  output logic                   o_dq_oe
);

  localparam int SETUP_RAW = (`FAM_T_SETUP_NS * `FAM_CLK_MHZ + 999) / 1000;
  localparam int WE_RAW    = (`FAM_T_WE_PULSE_NS * `FAM_CLK_MHZ + 999) / 1000;
  localparam int HOLD_RAW  = (`FAM_T_HOLD_NS * `FAM_CLK_MHZ + 999) / 1000;
  localparam int RD_RAW    = (`FAM_T_READ_NS * `FAM_CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = (SETUP_RAW < 1) ? 1 : SETUP_RAW;
  localparam int WE_CYC    = (WE_RAW < 1) ? 1 : WE_RAW;
  localparam int HOLD_CYC  = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
  localparam int RD_CYC    = (RD_RAW < 1) ? 1 : RD_RAW;

  typedef enum logic [1:0] {
    fam_b_idle   = 2'h0,
    fam_b_setup  = 2'h1,
    fam_b_strobe = 2'h2,
    fam_b_hold   = 2'h3
  } fam_bus_state_t;

  fam_bus_state_t    state, next_state;
  logic [7:0]        cnt, next_cnt;
  logic              is_read, next_is_read;
  logic              next_done, next_ce_n, next_we_n, next_oe_n, next_dq_oe;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_dq, next_rd_data;

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_is_read = is_read;
    next_done    = 1'b0;
    next_ce_n    = o_ce_n;
    next_we_n    = o_we_n;
    next_oe_n    = o_oe_n;
    next_dq_oe   = o_dq_oe;
    next_addr    = o_addr;
    next_dq      = o_dq;
    next_rd_data = o_rd_data;
    unique case (state)
      fam_b_idle: begin
        if (i_start) begin
          next_state   = fam_b_setup;
          next_cnt     = 8'(SETUP_CYC - 1);
          next_is_read = i_is_read;
          next_addr    = i_addr;
          next_dq      = i_data;
          next_dq_oe   = ~i_is_read;
          next_ce_n    = 1'b0;
        end
      end
      fam_b_setup: begin
        if (cnt == 8'h00) begin
          next_state = fam_b_strobe;
          next_cnt   = is_read ? 8'(RD_CYC - 1) : 8'(WE_CYC - 1);
          next_we_n  = is_read;
          next_oe_n  = ~is_read;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      fam_b_strobe: begin
        if (cnt == 8'h00) begin
          // Command latched on the rising write strobe; read data sampled here
          next_state = fam_b_hold;
          next_cnt   = 8'(HOLD_CYC - 1);
          next_we_n  = 1'b1;
          next_oe_n  = 1'b1;
          if (is_read) begin
            next_rd_data = i_dq;
          end
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      fam_b_hold: begin
        if (cnt == 8'h00) begin
          next_state = fam_b_idle;
          next_ce_n  = 1'b1;
          next_dq_oe = 1'b0;
          next_done  = 1'b1;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state     <= fam_b_idle;
      cnt       <= 8'h00;
      is_read   <= 1'b0;
      o_done    <= 1'b0;
      o_ce_n    <= 1'b1;
      o_we_n    <= 1'b1;
      o_oe_n    <= 1'b1;
      o_dq_oe   <= 1'b0;
      o_addr    <= '0;
      o_dq      <= '0;
      o_rd_data <= '0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      is_read   <= next_is_read;
      o_done    <= next_done;
      o_ce_n    <= next_ce_n;
      o_we_n    <= next_we_n;
      o_oe_n    <= next_oe_n;
      o_dq_oe   <= next_dq_oe;
      o_addr    <= next_addr;
      o_dq      <= next_dq;
      o_rd_data <= next_rd_data;
    end
  end

endmodule

`default_nettype wire

/* test/fam_host_properties.sv */
// Purpose: Port checks on the auxiliary-mode flash command host
// Assumes: Mode mirror settles a few cycles after the write strobe
// Notes:   Bound into every fam_host instance
`timescale 1ns/10ps
`default_nettype none

module fam_host_properties #(
  parameter int ADDR_W = 26,
  parameter int DATA_W = 16
) (
  input wire logic              i_clk_sys,
  input wire logic              i_resetn,
  input wire logic              i_cmd_valid,
  input wire logic [3:0]        i_cmd_op,
  input wire logic [ADDR_W-1:0] i_cmd_addr,
  input wire logic [DATA_W-1:0] i_cmd_data,
  input wire logic              i_abort_cond,
  input wire logic [DATA_W-1:0] i_dq,
  input wire logic              o_cmd_ready,
  input wire logic              o_done,
  input wire logic [DATA_W-1:0] o_rd_data,
  input wire logic [3:0]        o_mode,
  input wire logic              o_ce_n,
  input wire logic              o_we_n,
  input wire logic              o_oe_n,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic [DATA_W-1:0] o_dq,
  input wire logic              o_dq_oe
);
  logic        we_q;
  logic        wr;
  logic [7:0]  cmd;
  logic [11:0] ca;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      we_q <= 1'b1;
    end else begin
      we_q <= o_we_n;
    end
  end
  // First cycle of a write strobe, while the mirror still shows the old mode
  assign wr  = !o_we_n && we_q;
  assign cmd = o_dq[7:0];
  assign ca  = o_addr[11:0];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  AST_DONE_PULSE:
    assert property ($rose(o_done) |=> !o_done) else $error("done longer than a cycle");
  AST_WE_STROBE:
    assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe) else $error("bad write strobes");
  AST_WE_PULSE:
    assert property ($fell(o_we_n) |=> o_we_n && $stable(o_addr) && $stable(o_dq))
      else $error("write pulse not one cycle with stable bus");
  AST_EXIT_F0:
    assert property (wr && cmd == 8'hf0 && o_mode inside {fam_pkg::lockreg_mode,
      fam_pkg::query_mode, fam_pkg::secure_sector_mode} |-> ##[1:6] o_mode == 4'h0)
      else $error("reset write did not reach read array");
  AST_LR_CLEAR:
    assert property (wr && cmd == 8'h71 && ca == 12'h555 && o_mode == fam_pkg::lockreg_mode
      |=> (o_mode == fam_pkg::lockreg_mode) [*3]) else $error("clear left lock mode");
  AST_LR_EXIT:
    assert property (wr && cmd == 8'h90 && o_mode == fam_pkg::lockreg_mode
      |-> ##[1:6] o_mode == fam_pkg::lockreg_exit_pending) else $error("no exit pending");
  AST_SEC_UNLOCK:
    assert property (wr && cmd == 8'haa && ca == 12'h555 && o_mode == fam_pkg::secure_sector_mode
      |-> ##[1:6] o_mode == fam_pkg::secure_unlock_first) else $error("unlock one missed");
  AST_UL2_PROG:
    assert property (wr && cmd == 8'ha0 && ca == 12'h555 && o_mode == fam_pkg::secure_unlock_second
      |-> ##[1:6] o_mode == fam_pkg::secure_word_prog_wait) else $error("word program missed");
  AST_UL1_ABORT:
    assert property (wr && i_abort_cond && o_mode == fam_pkg::secure_unlock_first
      && !(cmd inside {8'hf0, 8'h70}) && !(ca == 12'h2aa && cmd == 8'h55)
      |-> ##[1:6] o_mode == fam_pkg::secure_programming) else $error("abort write missed");
endmodule

bind fam_host fam_host_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_fam_host_properties (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid),
  .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr), .i_cmd_data(i_cmd_data),
  .i_abort_cond(i_abort_cond), .i_dq(i_dq), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
  .o_rd_data(o_rd_data), .o_mode(o_mode), .o_ce_n(o_ce_n), .o_we_n(o_we_n),
  .o_oe_n(o_oe_n), .o_addr(o_addr), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
`default_nettype wire

/* test/fam_flash_model.sv */
// Purpose: Behavioural flash answering auxiliary-mode command writes
// Assumes: Writes latch on the rising write strobe with chip select low
// Notes:   i_set places the device in a mode, as other logic would
`timescale 1ns/10ps
`default_nettype none

module fam_flash_model #(
  parameter logic [15:0] QUERY_WORD  = 16'h0051,
  parameter logic [15:0] STATUS_WORD = 16'h0080
) (
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic [25:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_abort,
  input  wire logic        i_set,
  input  wire logic [3:0]  i_set_mode,
  output logic [15:0]      o_dq,
  output logic [3:0]       o_state
);
  fam_pkg::fam_mode_t st  = fam_pkg::read_array;
  fam_pkg::fam_mode_t ret = fam_pkg::read_array;
  logic [11:0]        a;
  logic [7:0]         d;
  logic               stat;
  initial o_dq = 16'h0;
  assign o_state = st;
  assign stat = st inside {fam_pkg::lockreg_status_read, fam_pkg::query_status_read,
                           fam_pkg::secure_status_read};
  task automatic sr(input fam_pkg::fam_mode_t s);
    ret = st;
    st  = s;
  endtask
  always @(posedge i_set) st = fam_pkg::fam_mode_t'(i_set_mode);
  always @(negedge i_oe_n) if (!i_ce_n) o_dq = stat ? STATUS_WORD :
    (st == fam_pkg::query_mode) ? QUERY_WORD : i_addr[15:0];
  // Released bus flips instead of holding the last word
  always @(posedge i_oe_n) begin
    o_dq = ~o_dq;
    if (stat) st = ret;
  end
  always @(posedge i_we_n) begin
    if (!i_ce_n) begin
      a = i_addr[11:0];
      d = i_dq[7:0];
      case (st)
        fam_pkg::lockreg_mode: begin
          if (d == 8'hf0) st = fam_pkg::read_array;
          else if (d == 8'h70 && a == 12'h555) sr(fam_pkg::lockreg_status_read);
          else if (d == 8'h90) st = fam_pkg::lockreg_exit_pending;
          else if (d == 8'ha0) st = fam_pkg::lockreg_prog_wait;
        end
        fam_pkg::lockreg_prog_wait: st = fam_pkg::lockreg_programming;
        fam_pkg::lockreg_exit_pending: if (d == 8'h00 || d == 8'h03) st = fam_pkg::read_array;
        fam_pkg::query_mode: begin
          if (d == 8'hf0) st = fam_pkg::read_array;
          else if (d == 8'h70 && a == 12'h555) sr(fam_pkg::query_status_read);
        end
        fam_pkg::secure_sector_mode: begin
          if (d == 8'hf0) st = fam_pkg::read_array;
          else if (d == 8'h70 && a == 12'h555) sr(fam_pkg::secure_status_read);
          else if (d == 8'haa && a == 12'h555) st = fam_pkg::secure_unlock_first;
        end
        fam_pkg::secure_unlock_first: begin
          if (d == 8'h55 && a == 12'h2aa) st = fam_pkg::secure_unlock_second;
          else if (d == 8'hf0) st = fam_pkg::read_array;
          else if (i_abort) st = fam_pkg::secure_programming;
        end
        fam_pkg::secure_unlock_second: begin
          if (d == 8'hf0) st = fam_pkg::secure_sector_mode;
          else if (d == 8'ha0 && a == 12'h555) st = fam_pkg::secure_word_prog_wait;
          else if (d == 8'h25) st = fam_pkg::secure_buffer_write;
          else if (d == 8'h90 && a == 12'h555) st = fam_pkg::secure_exit_pending;
          else if (i_abort) st = fam_pkg::secure_programming;
        end
        fam_pkg::secure_word_prog_wait: st = fam_pkg::secure_programming;
        fam_pkg::secure_exit_pending: if (d == 8'h00) st = fam_pkg::read_array;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

/* test/tb.sv */
// Purpose: Self-checking bench for the auxiliary-mode flash command host
// Assumes: Flash model decodes the host's pins on its own
// Notes:   Table entry: start mode, op, abort, expected mode
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end

module tb;
  localparam logic [15:0] QW = 16'h0051;
  localparam logic [15:0] SW = 16'h0080;
  localparam logic [15:0] TBL [20] = '{
    16'h1100, 16'h1201, 16'h1301, 16'h1400, 16'h1503, 16'h5a00,
    16'h6006, 16'h6100, 16'h6206, 16'h6306,
    16'h8100, 16'h8208, 16'h860b, 16'h8a0a,
    16'hb108, 16'hb70d, 16'hb80e, 16'hb900,
    16'haa1d, 16'hba1d};
  logic        clk    = 1'b0;
  logic        resetn = 1'b0;
  logic        valid  = 1'b0;
  logic [3:0]  op     = 4'h0;
  logic [25:0] addr   = 26'h0;
  logic [15:0] data   = 16'h0;
  logic        abort  = 1'b0;
  logic        set    = 1'b0;
  logic        ready, done, ce_n, we_n, oe_n, dq_oe;
  logic [15:0] rd, h_dq, m_dq;
  logic [25:0] h_addr;
  logic [3:0]  mode, m_state;
  wire logic [15:0] bus;
  int          fail_count  = 0;
  int          check_count = 0;
  integer      seed        = 32'h8261c71f;

  always #50 clk = ~clk;
  assign bus = dq_oe ? h_dq : m_dq;

  fam_host i_fam_host (.i_clk_sys(clk), .i_resetn(resetn), .i_cmd_valid(valid), .i_cmd_op(op),
    .i_cmd_addr(addr), .i_cmd_data(data), .i_abort_cond(abort), .i_dq(bus),
    .o_cmd_ready(ready), .o_done(done), .o_rd_data(rd), .o_mode(mode), .o_ce_n(ce_n),
    .o_we_n(we_n), .o_oe_n(oe_n), .o_addr(h_addr), .o_dq(h_dq), .o_dq_oe(dq_oe));
  fam_flash_model #(.QUERY_WORD(QW), .STATUS_WORD(SW)) i_fam_flash_model (.i_ce_n(ce_n),
    .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(h_addr), .i_dq(bus), .i_abort(abort),
    .i_set(set), .i_set_mode(data[3:0]), .o_dq(m_dq), .o_state(m_state));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Request held until an edge with ready high takes it
  task automatic run(input logic [3:0] o, input logic [25:0] a, input logic [15:0] d);
    int n;
    n     = 0;
    valid = 1'b1;
    op    = o;
    addr  = a;
    data  = d;
    while (ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
    valid = 1'b0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk) #1;
      n++;
    end
    `CHK({done, ready}, 2'b11)
    @(posedge clk) #1;
  endtask

  task automatic put(input logic [3:0] m);
    data = {12'h0, m};
    set  = 1'b1;
    run(4'hb, 26'h0, {12'h0, m});
    set  = 1'b0;
  endtask

  task automatic scen(input logic [15:0] e);
    logic [25:0] a;
    logic [15:0] d;
    a = 26'($random(seed));
    d = 16'($random(seed));
    if (e[11:8] == 4'ha && e[15:12] == 4'h8) begin
      a[11:0] = 12'h555;
      d[7:0]  = 8'haa;
    end else if (e[11:8] == 4'ha) begin
      a[11:8] = 4'h1;
      d[7:4]  = 4'h0;
    end
    if (e[15:12] == 4'h5) d[7:0] = 8'h03;
    put(e[15:12]);
    abort = e[4];
    run(e[11:8], a, d);
    abort = 1'b0;
    `CHK(mode, e[3:0])
    `CHK(m_state, e[3:0])
    if (e[11:8] == 4'h0) `CHK(rd, QW)
    if (e[11:8] == 4'h2) `CHK(rd, SW)
    $display("test from mode %h op %h ended", e[15:12], e[11:8]);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    @(posedge clk) #1;
    for (int i = 0; i < 20; i++) scen(TBL[i]);
    repeat (40) scen(TBL[$unsigned($random(seed)) % 20]);
    stop_test();
  end

  initial begin
    #2_000_000;
    fail_count++;
    $display("[ERR] t=%0t watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire
